/* hw/io_image_bank.sv */
// Purpose: Cyclic network image bank of the safety relay.
// Assumes: Image ports and relay status are synchronous to mclk.
// Notes:   Reads answer one cycle after the request.
`timescale 1ns/1ps

// Summary of operation
// - Command image bytes 0-1 feed communication inputs
// - Run flag: 1 run, 0 idle/program
// - Link flag: 1 when connection faulted
// - Major flag set while nonrecoverable fault present
// - Minor flag set while recoverable fault present
// - Verification id 1-9999, zero when unverified
// - Major category is one-hot eight-bit code
// - Major detail code names fault within category
// - Minor category 10h monitoring, 40h output
// - Minor fault instance runs 1 through 24
// - Sixteen-bit minor detail code per instance
// - Echo base point states, one bit each
// - Echo slot 2 plug-in point states
// - Block states, block n on bit n-1
// - Reset-required bit while output awaits reset
// - Status byte 0, id and faults bytes 2-9
// - Echoes, states, reset bits then reserved bytes
module io_image_bank
	import io_image_pkg::*;
#(
	parameter int PT_N  = 22,
	parameter int S2_IN = 4,
	parameter int MON_N = 24
)(
	input  wire logic              mclk,
	input  wire logic              nrst,
	input  wire logic              rx_wr,
	input  wire logic [1:0]        rx_addr,
	input  wire logic [7:0]        rx_data,
	input  wire logic              tx_rd,
	input  wire logic [4:0]        tx_addr,
	output logic      [7:0]        tx_data,
	output logic                   tx_valid,
	output logic      [15:0]       controller_command_bits,
	input  wire logic              run_mode_in,
	input  wire logic              link_fault_in,
	input  wire logic              cfg_verified,
	input  wire logic [15:0]       cfg_id,
	input  wire logic              maj_present,
	input  wire logic [7:0]        maj_cat_in,
	input  wire logic [7:0]        maj_code_in,
	input  wire logic              min_present,
	input  wire logic [7:0]        min_cat_in,
	input  wire logic [7:0]        min_inst_in,
	input  wire logic [15:0]       min_code_in,
	input  wire logic [PT_N-1:0]   point_state_echo,
	input  wire logic [S2_IN-1:0]  slot2_input_echo,
	input  wire logic [7-S2_IN:0]  slot2_output_echo,
	input  wire logic [MON_N-1:0]  monitoring_function_state,
	input  wire logic [15:0]       logic_tier_a_state,
	input  wire logic [15:0]       logic_tier_b_state,
	input  wire logic [15:0]       output_function_state,
	input  wire logic [15:0]       output_awaiting_reset,
	output logic                   operating_state_flag,
	output logic                   link_lost_flag,
	output logic                   nonrecoverable_fault_flag,
	output logic                   recoverable_fault_flag
);
	// ****************************************************************
	// State
	// ****************************************************************
	typedef struct packed {
		logic [15:0]      cmd;
		logic             run;
		logic             lost;
		logic [15:0]      vid;
		logic [23:0]      pt;
		logic [7:0]       s2;
		logic [23:0]      mon;
		logic [15:0]      tier_a;
		logic [15:0]      tier_b;
		logic [15:0]      sof;
		logic [15:0]      rr;
		logic [7:0]       rd;
		logic             rdv;
	} bank_t;

	bank_t st_ff;
	bank_t nxt_st;

	fault_if fif ();

	fault_capture u_fault (
		.mclk        (mclk),
		.nrst        (nrst),
		.maj_present (maj_present),
		.maj_cat_in  (maj_cat_in),
		.maj_code_in (maj_code_in),
		.min_present (min_present),
		.min_cat_in  (min_cat_in),
		.min_inst_in (min_inst_in),
		.min_code_in (min_code_in),
		.f           (fif.src)
	);

	// ****************************************************************
	// Input image byte decode
	// ****************************************************************
	function automatic logic [7:0] img_byte(input bank_t s, input logic [4:0] a,
		input logic [7:0] mcat, input logic [7:0] mcode, input logic [7:0] ncat,
		input logic [7:0] ninst, input logic [15:0] ncode, input logic mj,
		input logic mn);
		logic [7:0] b;
		b = BYTE_ZERO;
		case (a)
			TX_STATUS: begin
				b[BIT_RUN]  = s.run;
				b[BIT_LOST] = s.lost;
				b[BIT_MAJ]  = mj;
				b[BIT_MIN]  = mn;
			end
			TX_VID_LO:      b = s.vid[7:0];
			TX_VID_HI:      b = s.vid[15:8];
			TX_MAJ_CODE:    b = mcode;
			TX_MAJ_CAT:     b = mcat;
			TX_MIN_INST:    b = ninst;
			TX_MIN_CAT:     b = ncat;
			TX_MIN_CODE_LO: b = ncode[7:0];
			TX_MIN_CODE_HI: b = ncode[15:8];
			TX_PT0:         b = s.pt[7:0];
			TX_PT1:         b = s.pt[15:8];
			TX_PT2:         b = s.pt[23:16];
			TX_SLOT2:       b = s.s2;
			TX_MON0:        b = s.mon[7:0];
			TX_MON1:        b = s.mon[15:8];
			TX_MON2:        b = s.mon[23:16];
			TX_TIER_A0:     b = s.tier_a[7:0];
			TX_TIER_A1:     b = s.tier_a[15:8];
			TX_TIER_B0:     b = s.tier_b[7:0];
			TX_TIER_B1:     b = s.tier_b[15:8];
			TX_SOF0:        b = s.sof[7:0];
			TX_SOF1:        b = s.sof[15:8];
			TX_RR0:         b = s.rr[7:0];
			TX_RR1:         b = s.rr[15:8];
			default:        b = BYTE_ZERO;
		endcase
		return b;
	endfunction : img_byte

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		nxt_st = st_ff;
		// Only bytes 0 and 1 carry commands; reserved bytes 2-3 are dropped.
		if (rx_wr && (rx_addr == RX_CMD_LO)) begin
			nxt_st.cmd[7:0] = rx_data;
		end
		if (rx_wr && (rx_addr == RX_CMD_HI)) begin
			nxt_st.cmd[15:8] = rx_data;
		end
		nxt_st.run  = run_mode_in;
		nxt_st.lost = link_fault_in;
		// An out-of-range id is treated as unverified rather than shown raw.
		if (cfg_verified && (cfg_id != VID_NONE) && (cfg_id <= VID_MAX)) begin
			nxt_st.vid = cfg_id;
		end else begin
			nxt_st.vid = VID_NONE;
		end
		nxt_st.pt             = '0;
		nxt_st.pt[PT_N-1:0]   = point_state_echo;
		nxt_st.s2             = {slot2_output_echo, slot2_input_echo};
		nxt_st.mon            = '0;
		nxt_st.mon[MON_N-1:0] = monitoring_function_state;
		nxt_st.tier_a         = logic_tier_a_state;
		nxt_st.tier_b         = logic_tier_b_state;
		nxt_st.sof            = output_function_state;
		nxt_st.rr             = output_awaiting_reset;
		nxt_st.rdv            = tx_rd;
		if (tx_rd) begin
			nxt_st.rd = img_byte(st_ff, tx_addr, fif.maj_cat, fif.maj_code,
				fif.min_cat, fif.min_inst, fif.min_code, fif.maj_flag,
				fif.min_flag);
		end else begin
			nxt_st.rd = BYTE_ZERO;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_ff     <= '0;
			st_ff.cmd <= CMD_RST;
			st_ff.vid <= VID_NONE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign controller_command_bits   = st_ff.cmd;
	assign tx_data                   = st_ff.rd;
	assign tx_valid                  = st_ff.rdv;
	assign operating_state_flag      = st_ff.run;
	assign link_lost_flag            = st_ff.lost;
	assign nonrecoverable_fault_flag = fif.maj_flag;
	assign recoverable_fault_flag    = fif.min_flag;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	property p_cmd_lo;
		rx_wr && rx_addr == RX_CMD_LO |=> controller_command_bits[7:0] == $past(rx_data);
	endproperty
	a_cmd_lo: assert property (p_cmd_lo) else $error("command low byte not taken");

	property p_cmd_hi;
		rx_wr && rx_addr == RX_CMD_HI |=> controller_command_bits[15:8] == $past(rx_data);
	endproperty
	a_cmd_hi: assert property (p_cmd_hi) else $error("command high byte not taken");

	property p_rsvd_wr;
		rx_wr && rx_addr[1] |=> $stable(controller_command_bits);
	endproperty
	a_rsvd_wr: assert property (p_rsvd_wr) else $error("reserved write changed commands");

	property p_run;
		run_mode_in ##1 tx_rd && tx_addr == TX_STATUS |=> tx_data[BIT_RUN];
	endproperty
	a_run: assert property (p_run) else $error("run flag missing from status");

	property p_lost;
		$rose(link_fault_in) |=> link_lost_flag;
	endproperty
	a_lost: assert property (p_lost) else $error("link loss not reported");

	property p_maj;
		maj_present |=> nonrecoverable_fault_flag && one_hot8(fif.maj_cat);
	endproperty
	a_maj: assert property (p_maj) else $error("major fault not reported");

	property p_min;
		!min_present |=> !recoverable_fault_flag && fif.min_code == 16'h0000;
	endproperty
	a_min: assert property (p_min) else $error("minor fault flag stuck");

	property p_vid;
		!cfg_verified ##1 tx_rd && tx_addr == TX_VID_LO |=> tx_data == 8'h00;
	endproperty
	a_vid: assert property (p_vid) else $error("unverified id not zero");

	property p_vid_rng;
		cfg_id > VID_MAX ##1 tx_rd && tx_addr == TX_VID_HI |=> tx_data == 8'h00;
	endproperty
	a_vid_rng: assert property (p_vid_rng) else $error("id above range");

	property p_mcode;
		!maj_present |=> fif.maj_code == 8'h00 && fif.maj_cat == 8'h00;
	endproperty
	a_mcode: assert property (p_mcode) else $error("major fields not cleared");

	property p_ninst;
		fif.min_cat != 8'h00 |-> (fif.min_cat == MIN_MON || fif.min_cat == MIN_SOF)
			&& fif.min_inst >= INST_MIN && fif.min_inst <= INST_MAX;
	endproperty
	a_ninst: assert property (p_ninst) else $error("minor kind or instance bad");

	property p_pt;
		##1 tx_rd && tx_addr == TX_PT0 |=> tx_data == $past(point_state_echo[7:0], 2);
	endproperty
	a_pt: assert property (p_pt) else $error("point echo wrong");

	property p_s2;
		##1 tx_rd && tx_addr == TX_SLOT2 |=> tx_data == $past({slot2_output_echo,
			slot2_input_echo}, 2);
	endproperty
	a_s2: assert property (p_s2) else $error("slot 2 echo wrong");

	property p_mon;
		##1 tx_rd && tx_addr == TX_MON0 |=> tx_data == $past(monitoring_function_state[7:0], 2);
	endproperty
	a_mon: assert property (p_mon) else $error("block state wrong");

	property p_rr;
		##1 tx_rd && tx_addr == TX_RR1 |=> tx_data == $past(output_awaiting_reset[15:8], 2);
	endproperty
	a_rr: assert property (p_rr) else $error("reset-required byte wrong");

	property p_stat_rsvd;
		tx_rd && tx_addr == TX_STATUS |=> tx_data[7:4] == 4'h0;
	endproperty
	a_stat_rsvd: assert property (p_stat_rsvd) else $error("status reserved bits set");

	property p_tail;
		tx_rd && tx_addr > TX_RR1 |=> tx_valid && tx_data == 8'h00;
	endproperty
	a_tail: assert property (p_tail) else $error("reserved tail not zero");

	c_cmd: cover property (rx_wr && rx_addr == RX_CMD_HI ##1 rx_wr && rx_addr == RX_CMD_LO);
	c_maj: cover property (maj_present ##1 tx_rd && tx_addr == TX_MAJ_CAT);
	c_min: cover property (min_present && min_cat_in == MIN_SOF ##1 recoverable_fault_flag);
	c_vid: cover property (cfg_verified ##2 st_ff.vid != VID_NONE);
endmodule : io_image_bank

/* pkg/io_image_pkg.sv */
// Purpose: Shared layout of the two cyclic network images.
// Assumes: Byte-wide access to both images.
// Notes:   Offsets are byte indexes within each image.
package io_image_pkg;
	localparam int         OUT_ASM_INST   = 150;
	localparam int         IN_ASM_INST    = 100;
	localparam logic [1:0] RX_CMD_LO      = 2'h0;
	localparam logic [1:0] RX_CMD_HI      = 2'h1;
	localparam logic [4:0] TX_STATUS      = 5'h00;
	localparam logic [4:0] TX_VID_LO      = 5'h02;
	localparam logic [4:0] TX_VID_HI      = 5'h03;
	localparam logic [4:0] TX_MAJ_CODE    = 5'h04;
	localparam logic [4:0] TX_MAJ_CAT     = 5'h05;
	localparam logic [4:0] TX_MIN_INST    = 5'h06;
	localparam logic [4:0] TX_MIN_CAT     = 5'h07;
	localparam logic [4:0] TX_MIN_CODE_LO = 5'h08;
	localparam logic [4:0] TX_MIN_CODE_HI = 5'h09;
	localparam logic [4:0] TX_PT0         = 5'h0A;
	localparam logic [4:0] TX_PT1         = 5'h0B;
	localparam logic [4:0] TX_PT2         = 5'h0C;
	localparam logic [4:0] TX_SLOT2       = 5'h0D;
	localparam logic [4:0] TX_MON0        = 5'h0E;
	localparam logic [4:0] TX_MON1        = 5'h0F;
	localparam logic [4:0] TX_MON2        = 5'h10;
	localparam logic [4:0] TX_TIER_A0     = 5'h11;
	localparam logic [4:0] TX_TIER_A1     = 5'h12;
	localparam logic [4:0] TX_TIER_B0     = 5'h13;
	localparam logic [4:0] TX_TIER_B1     = 5'h14;
	localparam logic [4:0] TX_SOF0        = 5'h15;
	localparam logic [4:0] TX_SOF1        = 5'h16;
	localparam logic [4:0] TX_RR0         = 5'h17;
	localparam logic [4:0] TX_RR1         = 5'h18;
	localparam logic [4:0] TX_LAST        = 5'h1B;
	localparam int         BIT_RUN        = 0;
	localparam int         BIT_LOST       = 1;
	localparam int         BIT_MAJ        = 2;
	localparam int         BIT_MIN        = 3;
	localparam logic [7:0] MAJ_HW         = 8'h01;
	localparam logic [7:0] MIN_MON        = 8'h10;
	localparam logic [7:0] MIN_SOF        = 8'h40;
	localparam logic [7:0] INST_MIN       = 8'h01;
	localparam logic [7:0] INST_MAX       = 8'h18;
	localparam logic [15:0] VID_MAX       = 16'h270F;
	localparam logic [15:0] VID_NONE      = 16'h0000;
	localparam logic [15:0] CMD_RST       = 16'h0000;
	localparam logic [7:0] BYTE_ZERO      = 8'h00;

	function automatic logic one_hot8(input logic [7:0] v);
		return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
	endfunction : one_hot8
endpackage : io_image_pkg

/* pkg/fault_if.sv */
// Purpose: Carries the registered fault fields to the image bank.
// Assumes: Single clock domain.
// Notes:   All fields are zero when their flag is clear.
`timescale 1ns/1ps
interface fault_if;
	logic       maj_flag;
	logic [7:0] maj_cat;
	logic [7:0] maj_code;
	logic       min_flag;
	logic [7:0] min_cat;
	logic [7:0] min_inst;
	logic [15:0] min_code;
	modport src (output maj_flag, maj_cat, maj_code, min_flag, min_cat, min_inst, min_code);
	modport dst (input maj_flag, maj_cat, maj_code, min_flag, min_cat, min_inst, min_code);
endinterface : fault_if

/* hw/fault_capture.sv */
// Purpose: Registers and checks the fault report for the input image.
// Assumes: Fault inputs are synchronous to mclk.
// Notes:   Malformed major categories are reported as hardware, malformed minor reports keep their flag but read zero fields; never passed raw.
`timescale 1ns/1ps
module fault_capture
	import io_image_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        nrst,
	input  wire logic        maj_present,
	input  wire logic [7:0]  maj_cat_in,
	input  wire logic [7:0]  maj_code_in,
	input  wire logic        min_present,
	input  wire logic [7:0]  min_cat_in,
	input  wire logic [7:0]  min_inst_in,
	input  wire logic [15:0] min_code_in,
	fault_if.src             f
);
	typedef struct packed {
		logic        maj;
		logic [7:0]  mcat;
		logic [7:0]  mcode;
		logic        mnr;
		logic [7:0]  ncat;
		logic [7:0]  ninst;
		logic [15:0] ncode;
	} flt_t;

	flt_t st_ff;
	flt_t nxt_st;
	logic min_ok;

	always_comb begin
		nxt_st = '0;
		min_ok = ((min_cat_in == MIN_MON) || (min_cat_in == MIN_SOF))
			&& (min_inst_in >= INST_MIN) && (min_inst_in <= INST_MAX);
		nxt_st.maj = maj_present;
		if (maj_present) begin
			// A category that is not one-hot cannot be decoded, so call it hardware.
			nxt_st.mcat  = one_hot8(maj_cat_in) ? maj_cat_in : MAJ_HW;
			nxt_st.mcode = maj_code_in;
		end
		nxt_st.mnr = min_present;
		if (min_present && min_ok) begin
			nxt_st.ncat  = min_cat_in;
			nxt_st.ninst = min_inst_in;
			nxt_st.ncode = min_code_in;
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign f.maj_flag = st_ff.maj;
	assign f.maj_cat  = st_ff.mcat;
	assign f.maj_code = st_ff.mcode;
	assign f.min_flag = st_ff.mnr;
	assign f.min_cat  = st_ff.ncat;
	assign f.min_inst = st_ff.ninst;
	assign f.min_code = st_ff.ncode;
endmodule : fault_capture

/* bench/controller_model.sv */
// Purpose: Behavioural supervising controller on the far side of the image ports.
// Assumes: One strobe cycle per byte, requests launched just after a rising edge.
// Notes:   Released rx_data and tx_addr carry the inverse of their last value; rx_addr holds.
`timescale 1ns/1ps
module controller_model (
	input  wire logic       mclk,
	output logic            rx_wr,
	output logic [1:0]      rx_addr,
	output logic [7:0]      rx_data,
	output logic            tx_rd,
	output logic [4:0]      tx_addr,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_valid
);
	// ****************************************
	// Byte cycles
	// ****************************************
	initial begin
		rx_wr   = 1'b0;
		rx_addr = 2'h0;
		rx_data = 8'h00;
		tx_rd   = 1'b0;
		tx_addr = 5'h00;
	end

	// Reserved bytes 2 and 3 are only sent nonzero when a test asks for it.
	task automatic put_byte(input logic [1:0] a, input logic [7:0] d);
		@(posedge mclk);
		rx_wr   <= 1'b1;
		rx_addr <= a;
		rx_data <= d;
		@(posedge mclk);
		rx_wr   <= 1'b0;
		rx_data <= ~d;
	endtask : put_byte

	// Echo and reserved bytes are only handed back, never acted upon.
	task automatic get_byte(input logic [4:0] a, output logic [7:0] d, output logic v);
		@(posedge mclk);
		tx_rd   <= 1'b1;
		tx_addr <= a;
		@(posedge mclk);
		tx_rd   <= 1'b0;
		tx_addr <= ~a;
		#1;
		d = tx_data;
		v = tx_valid;
	endtask : get_byte
endmodule : controller_model

/* bench/test_safety_relay_network_io_image.sv */
// Purpose: Self-checking bench for the relay network image bank.
// Assumes: Default image parameters: 22 points, 4+4 slot bits, 24 monitors.
// Notes:   Table rows cover the full status image; odd cases follow by hand.
`timescale 1ns/1ps
module test_safety_relay_network_io_image
	import io_image_pkg::*;
;
	typedef struct packed {logic [4:0] addr; logic [7:0] exp;} row_t;
	logic        mclk, nrst, rx_wr, tx_rd, tx_valid, run_mode_in, link_fault_in, cfg_verified;
	logic        maj_present, min_present, operating_state_flag, link_lost_flag;
	logic        nonrecoverable_fault_flag, recoverable_fault_flag;
	logic [1:0]  rx_addr;
	logic [4:0]  tx_addr;
	logic [7:0]  rx_data, tx_data, maj_cat_in, maj_code_in, min_cat_in, min_inst_in;
	logic [15:0] controller_command_bits, cfg_id, min_code_in, logic_tier_a_state;
	logic [15:0] logic_tier_b_state, output_function_state, output_awaiting_reset;
	logic [21:0] point_state_echo;
	logic [3:0]  slot2_input_echo, slot2_output_echo;
	logic [23:0] monitoring_function_state;
	int          error_cnt, comparisons, cycles;
	row_t        rows[29] = '{'{5'h00,8'h0D},'{5'h01,8'h00},'{5'h02,8'h34},'{5'h03,8'h12},
		'{5'h04,8'h07},'{5'h05,8'h10},'{5'h06,8'h18},'{5'h07,8'h40},'{5'h08,8'hEF},
		'{5'h09,8'hBE},'{5'h0A,8'h3F},'{5'h0B,8'h5C},'{5'h0C,8'h2A},'{5'h0D,8'h69},
		'{5'h0E,8'h1E},'{5'h0F,8'hA5},'{5'h10,8'hC3},'{5'h11,8'h57},'{5'h12,8'h13},
		'{5'h13,8'hDF},'{5'h14,8'h9B},'{5'h15,8'h68},'{5'h16,8'h24},'{5'h17,8'h01},
		'{5'h18,8'h80},'{5'h19,8'h00},'{5'h1A,8'h00},'{5'h1B,8'h00},'{5'h1F,8'h00}};

	io_image_bank dut (.mclk, .nrst, .rx_wr, .rx_addr, .rx_data, .tx_rd, .tx_addr, .tx_data,
		.tx_valid, .controller_command_bits, .run_mode_in, .link_fault_in, .cfg_verified,
		.cfg_id, .maj_present, .maj_cat_in, .maj_code_in, .min_present, .min_cat_in,
		.min_inst_in, .min_code_in, .point_state_echo, .slot2_input_echo, .slot2_output_echo,
		.monitoring_function_state, .logic_tier_a_state, .logic_tier_b_state,
		.output_function_state, .output_awaiting_reset, .operating_state_flag,
		.link_lost_flag, .nonrecoverable_fault_flag, .recoverable_fault_flag);
	controller_model ctl (.mclk, .rx_wr, .rx_addr, .rx_data, .tx_rd, .tx_addr, .tx_data,
		.tx_valid);

	// ****************************************
	// Helpers
	// ****************************************
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : complete_run

	// The ceiling is about fifteen times the length of the planned sequence.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			complete_run();
		end
	end

	task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		logic [7:0] d;
		logic       v;
		ctl.get_byte(a, d, v);
		check("tx_valid", v, 1'b1);
		check("tx_data", d, exp);
	endtask : rd

	task automatic flags(input logic [3:0] exp);
		check("flags", {recoverable_fault_flag, nonrecoverable_fault_flag, link_lost_flag,
			operating_state_flag}, exp);
	endtask : flags

	task automatic stat(input logic run, input logic lost, input logic ver, input logic [15:0] id);
		@(posedge mclk);
		run_mode_in   <= run;
		link_fault_in <= lost;
		cfg_verified  <= ver;
		cfg_id        <= id;
	endtask : stat

	task automatic faults(input logic mj, input logic [7:0] mc, input logic [7:0] md,
		input logic mn, input logic [7:0] nc, input logic [7:0] ni, input logic [15:0] nd);
		@(posedge mclk);
		maj_present <= mj;
		maj_cat_in  <= mc;
		maj_code_in <= md;
		min_present <= mn;
		min_cat_in  <= nc;
		min_inst_in <= ni;
		min_code_in <= nd;
	endtask : faults

	// ****************************************
	// Sequence
	// ****************************************
	initial begin
		int         i;
		logic       ok;
		logic [7:0] mcat[5] = '{8'h10, 8'h40, 8'h40, 8'h10, 8'h20};
		logic [7:0] mins[5] = '{8'h01, 8'h18, 8'h19, 8'h00, 8'h05};
		logic [16:0] vin[3] = '{17'h12710, 17'h01234, 17'h10001};
		{run_mode_in, link_fault_in, cfg_verified, cfg_id} = '0;
		{maj_present, maj_cat_in, maj_code_in, min_present, min_cat_in} = '0;
		{min_inst_in, min_code_in, point_state_echo, slot2_input_echo} = '0;
		{slot2_output_echo, monitoring_function_state, logic_tier_a_state} = '0;
		{logic_tier_b_state, output_function_state, output_awaiting_reset} = '0;
		nrst = 1'b0;
		repeat (10) @(posedge mclk);
		#1;
		check("cmd reset", controller_command_bits, 16'h0000);
		check("valid reset", tx_valid, 1'b0);
		flags(4'h0);
		@(posedge mclk);
		nrst <= 1'b1;
		$display("Test reset done");

		stat(1'b1, 1'b0, 1'b1, 16'h1234);
		faults(1'b1, 8'h10, 8'h07, 1'b1, 8'h40, 8'h18, 16'hBEEF);
		point_state_echo          <= 22'h2A5C3F;
		slot2_input_echo          <= 4'h9;
		slot2_output_echo         <= 4'h6;
		monitoring_function_state <= 24'hC3A51E;
		logic_tier_a_state        <= 16'h1357;
		logic_tier_b_state        <= 16'h9BDF;
		output_function_state     <= 16'h2468;
		output_awaiting_reset     <= 16'h8001;
		for (i = 0; i < 29; i++)
			rd(rows[i].addr, rows[i].exp);
		flags(4'hD);
		$display("Test image table done");

		ctl.put_byte(2'h0, 8'hA5);
		ctl.put_byte(2'h1, 8'h3C);
		#1;
		check("cmd", controller_command_bits, 16'h3CA5);
		ctl.put_byte(2'h2, 8'hFF);
		ctl.put_byte(2'h3, 8'hFF);
		ctl.put_byte(2'h0, 8'h01);
		#1;
		check("cmd", controller_command_bits, 16'h3C01);
		$display("Test commands done");

		stat(1'b0, 1'b1, 1'b1, VID_MAX);
		faults(1'b0, 8'h10, 8'h07, 1'b0, 8'h40, 8'h05, 16'h1234);
		rd(TX_STATUS, 8'h02);
		rd(TX_MAJ_CAT, 8'h00);
		rd(TX_MIN_CODE_LO, 8'h00);
		rd(TX_VID_LO, 8'h0F);
		rd(TX_VID_HI, 8'h27);
		flags(4'h2);
		for (i = 0; i < 3; i++) begin
			stat(1'b1, 1'b0, vin[i][16], vin[i][15:0]);
			ok = vin[i][16] && vin[i][15:0] != 16'h0000 && vin[i][15:0] <= VID_MAX;
			rd(TX_VID_LO, ok ? vin[i][7:0] : 8'h00);
			rd(TX_VID_HI, ok ? vin[i][15:8] : 8'h00);
		end
		$display("Test flags and id done");

		// Malformed categories must come out as the hardware category.
		for (i = 0; i < 10; i++) begin
			faults(1'b1, i < 8 ? 8'h01 << i : 8'h03 * (i - 8), 8'h0B, 1'b0, 8'h00, 8'h00, 16'h0);
			rd(TX_MAJ_CAT, i < 8 ? 8'h01 << i : MAJ_HW);
			rd(TX_MAJ_CODE, 8'h0B);
		end
		for (i = 0; i < 5; i++) begin
			faults(1'b0, 8'h00, 8'h00, 1'b1, mcat[i], mins[i], 16'hA55A);
			ok = (mcat[i] == 8'h10 || mcat[i] == 8'h40) && mins[i] >= 8'h01 && mins[i] <= 8'h18;
			rd(TX_MIN_CAT, ok ? mcat[i] : 8'h00);
			rd(TX_MIN_INST, ok ? mins[i] : 8'h00);
			rd(TX_MIN_CODE_HI, ok ? 8'hA5 : 8'h00);
			flags(4'h9);
		end
		$display("Test fault fields done");

		@(posedge mclk);
		nrst <= 1'b0;
		#1;
		check("cmd mid reset", controller_command_bits, 16'h0000);
		flags(4'h0);
		@(posedge mclk);
		nrst <= 1'b1;
		rd(TX_STATUS, 8'h09);
		$display("Test mid-run reset done");
		complete_run();
	end
endmodule : test_safety_relay_network_io_image
